// >>> design/gpio_led_pin_config.sv
// AHB-Lite slave holding the pin function register, pin muxing and level interrupt qualification
//
// Functional notes
// - LED select bit makes pin an LED
// - Polarity bit chooses active interrupt level
// - Interrupt only when pin enable also set
// - Level must persist beyond 40 ns
// - Select field routes serial memory pins
// - Drive type: push-pull or open-drain
// - Direction bit makes pin an output
// - Output-only pins show written value
// - Output pins drive written data bit
// - Data read returns sampled pin state
// - Select code table for memory pins
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pin_cfg_map.svh"

module gpio_led_pin_config #(
	parameter int NUM_PINS = 3
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Shared GPIO and LED pins
	input  wire logic [2:0]  gpio_in,
	output logic      [2:0]  gpio_out,
	output logic      [2:0]  gpio_oe,
	input  wire logic [2:0]  led_drive,
	// Interrupt enables and qualified events
	input  wire logic [2:0]  pin_irq_enable,
	output logic      [2:0]  pin_irq_event,
	// Internal sources for the serial memory pins
	input  wire logic        rom_data_out,
	input  wire logic        rom_data_oe,
	input  wire logic        rom_clock_out,
	input  wire logic        mac_tx_en,
	input  wire logic        mac_tx_clk,
	input  wire logic        phy_rx_dv,
	input  wire logic        phy_rx_clk,
	// Serial memory pins
	input  wire logic        rom_data_pin_in,
	output logic             rom_data_pin_out,
	output logic             rom_data_pin_oe,
	output logic             rom_clock_pin_out,
	output logic             rom_clock_pin_oe,
	output logic             rom_data_in,
	// Output-only pins
	output logic             output_only_pin_a,
	output logic             output_only_pin_b
);

	if (NUM_PINS != 3) begin : g_bad_pins
		$error("gpio_led_pin_config: only three shared pins are supported");
	end

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	//==========================================================
	// Input synchronisers and level qualifiers
	logic [2:0] pin_sync;
	logic [2:0] level_hit;
	logic [2:0] polarity;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_pin
			level_qualifier #(
				.MIN_CYCLES (`PIN_IRQ_MIN_CYCLES)
			) u_lq (
				.hclk      (hclk),
				.hresetn   (hresetn),
				.pin_raw   (gpio_in[gi]),
				.polarity  (polarity[gi]),
				.pin_sync  (pin_sync[gi]),
				.level_hit (level_hit[gi])
			);
		end
	endgenerate

	//==========================================================
	// State
	typedef struct packed {
		logic [31:0]            cfg;
		pin_cfg_pkg::bus_phase_t phase;
		logic [31:0]            rdata;
		logic [2:0]             gp_out;
		logic [2:0]             gp_oe;
		logic [2:0]             irq;
		logic                   rd_out;
		logic                   rd_oe;
		logic                   rc_out;
		logic                   rc_oe;
		logic                   rom_in;
		logic                   meta_rom;
		logic                   sync_rom;
	} top_state_t;

	top_state_t st;
	top_state_t next_st;

	logic [2:0]            led_sel;
	logic [2:0]            drive_type;
	logic [2:0]            direction;
	logic [2:0]            pin_value;
	logic [1:0]            output_only_value;
	pin_cfg_pkg::rom_sel_t serial_rom_pin_select;
	logic                  addr_hit;
	logic                  req;
	logic [2:0]            drv;

	assign led_sel               = st.cfg[`PIN_CFG_LED_LSB +: 3];
	assign polarity              = st.cfg[`PIN_CFG_POL_LSB +: 3];
	assign serial_rom_pin_select = pin_cfg_pkg::rom_sel_t'(st.cfg[`PIN_CFG_ROMSEL_LSB +: 3]);
	assign drive_type            = st.cfg[`PIN_CFG_DRIVE_LSB +: 3];
	assign direction             = st.cfg[`PIN_CFG_DIR_LSB +: 3];
	assign output_only_value     = st.cfg[`PIN_CFG_OUTONLY_LSB +: 2];
	assign pin_value             = st.cfg[`PIN_CFG_VALUE_LSB +: 3];
	assign req      = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign addr_hit = (haddr[7:0] == `PIN_CFG_OFFSET) && (haddr[31:8] == 24'h000000)
		&& (hsize == HSIZE_WORD);

	//==========================================================
	// Next state
	always_comb begin
		next_st          = st;
		drv              = 3'h0;
		next_st.meta_rom = rom_data_pin_in;
		next_st.sync_rom = st.meta_rom;
		next_st.rom_in   = st.sync_rom;

		if (st.phase == pin_cfg_pkg::BUS_WRITE) begin
			next_st.cfg = hwdata & `PIN_CFG_WRITE_MASK;
		end
		next_st.phase = pin_cfg_pkg::BUS_IDLE;
		if (req && addr_hit) begin
			next_st.phase = hwrite ? pin_cfg_pkg::BUS_WRITE : pin_cfg_pkg::BUS_READ;
		end
		next_st.rdata = 32'h0000_0000;
		if (req && addr_hit && !hwrite) begin
			next_st.rdata = next_st.cfg;
			next_st.rdata[`PIN_CFG_VALUE_LSB +: 3] = pin_sync;
		end

		for (int i = 0; i < 3; i++) begin
			if (led_sel[i]) begin
				drv[i] = led_drive[i];
				next_st.gp_oe[i] = 1'b1;
			end else begin
				drv[i] = pin_value[i];
				next_st.gp_oe[i] = direction[i];
			end
			if (drive_type[i] || led_sel[i]) begin
				next_st.gp_out[i] = drv[i];
			end else begin
				next_st.gp_out[i] = 1'b0;
				next_st.gp_oe[i]  = next_st.gp_oe[i] && !drv[i];
			end
			next_st.irq[i] = level_hit[i] && pin_irq_enable[i] && !led_sel[i];
		end

		next_st.rd_out = 1'b0;
		next_st.rd_oe  = 1'b0;
		next_st.rc_out = 1'b0;
		next_st.rc_oe  = 1'b0;
		unique case (serial_rom_pin_select)
			pin_cfg_pkg::ROM_SEL_ROM: begin
				next_st.rd_out = rom_data_out;
				next_st.rd_oe  = rom_data_oe;
				next_st.rc_out = rom_clock_out;
				next_st.rc_oe  = 1'b1;
			end
			pin_cfg_pkg::ROM_SEL_OUTONLY: begin
				next_st.rd_out = output_only_value[0];
				next_st.rd_oe  = 1'b1;
				next_st.rc_out = output_only_value[1];
				next_st.rc_oe  = 1'b1;
			end
			pin_cfg_pkg::ROM_SEL_OUT_RXDV: begin
				next_st.rd_out = output_only_value[0];
				next_st.rd_oe  = 1'b1;
				next_st.rc_out = phy_rx_dv;
				next_st.rc_oe  = 1'b1;
			end
			pin_cfg_pkg::ROM_SEL_TXEN_OUT: begin
				next_st.rd_out = mac_tx_en;
				next_st.rd_oe  = 1'b1;
				next_st.rc_out = output_only_value[1];
				next_st.rc_oe  = 1'b1;
			end
			pin_cfg_pkg::ROM_SEL_TXEN_RX: begin
				next_st.rd_out = mac_tx_en;
				next_st.rd_oe  = 1'b1;
				next_st.rc_out = phy_rx_dv;
				next_st.rc_oe  = 1'b1;
			end
			pin_cfg_pkg::ROM_SEL_CLKS: begin
				next_st.rd_out = mac_tx_clk;
				next_st.rd_oe  = 1'b1;
				next_st.rc_out = phy_rx_clk;
				next_st.rc_oe  = 1'b1;
			end
			// Reserved codes leave both pins undriven; software avoids them
			default: begin
				next_st.rd_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st       <= '0;
			st.cfg   <= `PIN_CFG_RESET;
			st.phase <= pin_cfg_pkg::BUS_IDLE;
		end else begin
			st <= next_st;
		end
	end

	//==========================================================
	// Outputs
	assign hrdata            = st.rdata;
	assign hreadyout         = 1'b1;
	assign hresp             = 1'b0;
	assign gpio_out          = st.gp_out;
	assign gpio_oe           = st.gp_oe;
	assign pin_irq_event     = st.irq;
	assign rom_data_pin_out  = st.rd_out;
	assign rom_data_pin_oe   = st.rd_oe;
	assign rom_clock_pin_out = st.rc_out;
	assign rom_clock_pin_oe  = st.rc_oe;
	assign rom_data_in       = st.rom_in;
	assign output_only_pin_a = st.cfg[`PIN_CFG_OUTONLY_LSB];
	assign output_only_pin_b = st.cfg[`PIN_CFG_OUTONLY_LSB + 1];

	//==========================================================
	// Assertions
	AST_LED_OE: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(led_sel[0]) |-> gpio_oe[0])
		else $error("LED pin not driven");
	AST_IRQ_NEEDS_EN: assert property (@(posedge hclk) disable iff (!hresetn)
		pin_irq_event[1] |-> $past(pin_irq_enable[1]))
		else $error("Interrupt without enable");
	AST_IRQ_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
		pin_irq_event[0] |-> $past(pin_sync[0] == polarity[0], 2))
		else $error("Interrupt on wrong level");
	AST_IRQ_DURATION: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(pin_irq_event[2]) |-> $past(pin_sync[2] == polarity[2], 3))
		else $error("Interrupt level too short");
	AST_OPEN_DRAIN: assert property (@(posedge hclk) disable iff (!hresetn)
		(gpio_oe[0] && !$past(drive_type[0] || led_sel[0])) |-> !gpio_out[0])
		else $error("Open drain drove high");
	AST_DIR_INPUT: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(!direction[1] && !led_sel[1]) |-> !gpio_oe[1])
		else $error("Input pin driven");
	AST_OUT_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
		output_only_pin_a == ($past(st.phase == pin_cfg_pkg::BUS_WRITE)
		? $past(hwdata[`PIN_CFG_OUTONLY_LSB]) : $past(output_only_pin_a)))
		else $error("Output-only pin differs from written value");
	AST_OUT_DATA: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(direction[2] && drive_type[2] && !led_sel[2]) |-> gpio_out[2] == $past(pin_value[2]))
		else $error("Output pin value wrong");
	AST_ROM_SEL: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(serial_rom_pin_select == pin_cfg_pkg::ROM_SEL_OUTONLY)
		|-> rom_clock_pin_out == $past(output_only_value[1]))
		else $error("Serial memory clock pin misrouted");
	AST_READ_PIN: assert property (@(posedge hclk) disable iff (!hresetn)
		(req && addr_hit && !hwrite) |=> hrdata[0] == $past(pin_sync[0]))
		else $error("Read data not sampled pin");
	COV_WRITE: cover property (@(posedge hclk) disable iff (!hresetn)
		st.phase == pin_cfg_pkg::BUS_WRITE);
	COV_READ: cover property (@(posedge hclk) disable iff (!hresetn)
		st.phase == pin_cfg_pkg::BUS_READ);
	COV_IRQ: cover property (@(posedge hclk) disable iff (!hresetn) pin_irq_event != 3'h0);
	COV_LED: cover property (@(posedge hclk) disable iff (!hresetn) led_sel != 3'h0);

endmodule : gpio_led_pin_config

`default_nettype wire

// >>> pkg/pin_cfg_map.svh
// Register offsets, field positions, reset values and timing counts for the pin configuration block
`ifndef PIN_CFG_MAP_SVH
`define PIN_CFG_MAP_SVH

`define PIN_CFG_OFFSET       8'h88
`define PIN_CFG_LED_LSB      28
`define PIN_CFG_POL_LSB      24
`define PIN_CFG_ROMSEL_LSB   20
`define PIN_CFG_DRIVE_LSB    16
`define PIN_CFG_DIR_LSB      8
`define PIN_CFG_OUTONLY_LSB  3
`define PIN_CFG_VALUE_LSB    0
`define PIN_CFG_RESET        32'h0000_0000
`define PIN_CFG_WRITE_MASK   32'h7777_071f
`define PIN_IRQ_MIN_NS       40
`define CLK_PERIOD_NS        100
// Longer than the least time: floor(ns / period) + 1 cycles
`define PIN_IRQ_MIN_CYCLES   ((`PIN_IRQ_MIN_NS / `CLK_PERIOD_NS) + 1)

`endif

// >>> pkg/pin_cfg_pkg.sv
// Types for the pin configuration block
package pin_cfg_pkg;

	typedef enum logic [2:0] {
		ROM_SEL_ROM      = 3'h0,
		ROM_SEL_OUTONLY  = 3'h1,
		ROM_SEL_RSVD_A   = 3'h2,
		ROM_SEL_OUT_RXDV = 3'h3,
		ROM_SEL_RSVD_B   = 3'h4,
		ROM_SEL_TXEN_OUT = 3'h5,
		ROM_SEL_TXEN_RX  = 3'h6,
		ROM_SEL_CLKS     = 3'h7
	} rom_sel_t;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ
	} bus_phase_t;

endpackage : pin_cfg_pkg

// >>> design/level_qualifier.sv
// Two-stage synchroniser followed by a level-duration qualifier for one pin
`timescale 1ns/1ps
`default_nettype none

module level_qualifier #(
	parameter int MIN_CYCLES = 1
) (
	// Clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// Pin and control
	input  wire logic pin_raw,
	input  wire logic polarity,
	// Results
	output logic      pin_sync,
	output logic      level_hit
);

	if (MIN_CYCLES < 1 || MIN_CYCLES > 255) begin : g_bad_min
		$error("level_qualifier: MIN_CYCLES out of range");
	end

	typedef struct packed {
		logic       meta;
		logic       sync;
		logic [7:0] count;
		logic       hit;
	} lq_state_t;

	lq_state_t st;
	lq_state_t next_st;

	always_comb begin
		next_st      = st;
		next_st.meta = pin_raw;
		next_st.sync = st.meta;
		next_st.hit  = 1'b0;
		if (st.sync == polarity) begin
			if (st.count >= 8'(MIN_CYCLES)) begin
				next_st.hit = 1'b1;
			end else begin
				next_st.count = st.count + 8'h01;
			end
		end else begin
			next_st.count = 8'h00;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pin_sync  = st.sync;
	assign level_hit = st.hit;

endmodule : level_qualifier

`default_nettype wire

// >>> test/pin_world.sv
// Far-side pin model: pads with pull-ups and an external driver
`timescale 1ns/1ps
`default_nettype none

module pin_world (
	// Device pin drive
	input  wire logic [2:0] gpio_out,
	input  wire logic [2:0] gpio_oe,
	input  wire logic       rom_data_pin_out,
	input  wire logic       rom_data_pin_oe,
	// External board driver
	input  wire logic [2:0] ext_en,
	input  wire logic [2:0] ext_val,
	// Pad levels back to the device
	output logic      [2:0] gpio_in,
	output logic            rom_data_pin_in
);
	// Undriven pads are pulled up
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			gpio_in[i] = gpio_oe[i] ? gpio_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
		end
		rom_data_pin_in = rom_data_pin_oe ? rom_data_pin_out : 1'b1;
	end
endmodule : pin_world

`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the pin configuration register block
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, smp = 0, dp_rd = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r, x = 32'h39, v;
	logic [1:0]  htrans = 0;
	logic [2:0]  gpio_in, gpio_out, gpio_oe, led_drive = 0, pin_irq_enable = 0, ev;
	logic [2:0]  ext_en = 0, ext_val = 0, code;
	logic        hreadyout, hresp, rdi, rdo, rdoe, rco, rcoe, opa, opb, rdin;
	logic        rom_data_out = 0, rom_data_oe = 0, rom_clock_out = 0;
	logic        mac_tx_en = 0, mac_tx_clk = 0, phy_rx_dv = 0, phy_rx_clk = 0;
	logic [63:0] e, q[$];
	logic [16:0] pins;
	int          fails = 0, num_checks = 0;
	logic [2:0]  codes[6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};

	// ==========================================
	// Design and pads
	gpio_led_pin_config DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gpio_in(gpio_in),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .led_drive(led_drive),
		.pin_irq_enable(pin_irq_enable), .pin_irq_event(ev), .rom_data_out(rom_data_out),
		.rom_data_oe(rom_data_oe), .rom_clock_out(rom_clock_out), .mac_tx_en(mac_tx_en),
		.mac_tx_clk(mac_tx_clk), .phy_rx_dv(phy_rx_dv), .phy_rx_clk(phy_rx_clk),
		.rom_data_pin_in(rdi), .rom_data_pin_out(rdo), .rom_data_pin_oe(rdoe),
		.rom_clock_pin_out(rco), .rom_clock_pin_oe(rcoe), .rom_data_in(rdin),
		.output_only_pin_a(opa), .output_only_pin_b(opb));
	pin_world pads (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .rom_data_pin_out(rdo),
		.rom_data_pin_oe(rdoe), .ext_en(ext_en), .ext_val(ext_val), .gpio_in(gpio_in),
		.rom_data_pin_in(rdi));
	assign pins = {hresp, rdin, rcoe, rco, rdoe, rdo, opb, opa, ev, gpio_oe, gpio_out};

	always #50 hclk = ~hclk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction : xs

	// ==========================================
	// Bus master and pin sampling
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		if (!w) q.push_back({32'hffff_ffff, d});
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask : bus

	task automatic pchk(input logic [31:0] m, input logic [31:0] ex);
		repeat (8) @(posedge hclk);
		q.push_back({m, ex});
		smp <= 1;
		@(posedge hclk);
		smp <= 0;
		@(posedge hclk);
	endtask : pchk

	// ==========================================
	// Result monitor
	always @(posedge hclk) begin
		if (dp_rd || smp) begin
			e = q.pop_front();
			v = dp_rd ? hrdata : {15'h0, pins};
			num_checks++;
			if ((v & e[63:32]) !== e[31:0]) begin
				fails++;
				$display("BAD t=%0t exp=%h got=%h", $time, e[31:0], v & e[63:32]);
			end
		end
		dp_rd = hsel && htrans == 2'h2 && !hwrite && hreadyout;
	end

	task automatic test_done;
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	initial begin
		#(3000 * 100);
		fails++;
		test_done();
	end

	// ==========================================
	// Scenarios
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1;
		// Pads need two synchroniser edges before a read shows them
		repeat (3) @(posedge hclk);
		bus(0, 32'h88, 32'h7);
		bus(1, 32'h8c, 32'hffff_ffff);
		bus(0, 32'h8c, 32'h0);
		bus(0, 32'h88, 32'h7);
		$display("reset and decode done");
		led_drive <= 3'h5;
		mac_tx_clk <= 1;
		bus(1, 32'h88, 32'hffff_ffff);
		pchk(32'h1_7fff, 32'h5e3d);
		bus(0, 32'h88, 32'h7777_071d);
		$display("mask and led done");
		x = xs(x);
		r = x & 32'h1f;
		bus(1, 32'h88, 32'h0017_0700 | r);
		pchk(32'h2e3f, r[2:0] | 32'h38 | r[3] << 9 | r[4] << 10 | r[3] << 11 | r[4] << 13);
		bus(0, 32'h88, 32'h0017_0700 | r);
		bus(1, 32'h88, 32'h0000_0702);
		pchk(32'h3f, 32'h28);
		bus(0, 32'h88, 32'h0000_0702);
		$display("output drive done");
		for (int p = 0; p < 2; p++) begin
			ext_en <= 3'h7;
			ext_val <= p ? 3'h5 : 3'h2;
			pin_irq_enable <= 3'h7;
			bus(1, 32'h88, p ? 32'h0700_0000 : 32'h0);
			pchk(32'h1f8, 32'h140);
			bus(0, 32'h88, (p ? 32'h0700_0000 : 32'h0) | (p ? 3'h5 : 3'h2));
		end
		ext_en <= 3'h0;
		$display("input and event done");
		foreach (codes[i]) begin
			code = codes[i];
			x = xs(x);
			{rom_data_out, rom_data_oe, rom_clock_out, mac_tx_en} <= x[3:0];
			{mac_tx_clk, phy_rx_dv, phy_rx_clk} <= x[6:4];
			bus(1, 32'h88, {9'h0, code, 20'h10});
			case (code)
				3'h0: v = {1'b1, rom_clock_out, rom_data_oe, rom_data_out};
				3'h1: v = 4'he;
				3'h3: v = {1'b1, phy_rx_dv, 2'h2};
				3'h5: v = {2'h3, 1'b1, mac_tx_en};
				3'h6: v = {1'b1, phy_rx_dv, 1'b1, mac_tx_en};
				default: v = {1'b1, phy_rx_clk, 1'b1, mac_tx_clk};
			endcase
			pchk(32'hf800, {v[1] ? v[0] : 1'b1, v[3:0]} << 11);
			bus(0, 32'h88, {9'h0, code, 20'h17});
		end
		$display("pin select done");
		repeat (4) @(posedge hclk);
		test_done();
	end
endmodule : tb

`default_nettype wire
